/* rtl/swc_sleep_wake.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sleep instruction enters power-down
// - Clear watchdog on entry; runs if enabled
// - Clear power-down flag on entry
// - Set timeout flag on entry
// - Gate core clock while asleep
// - Low-frequency oscillator keeps running asleep
// - Timer1 runs asleep on sleep-capable clocks
// - ADC runs asleep on dedicated RC
// - I/O ports hold state asleep
// - Sleep leaves non-watchdog resets unchanged
// - Listed reset and interrupt events wake
// - Resets reset device; others continue
// - Prefetch next instruction on sleep entry
// - Wake needs individual enable, not global
// - Global enable clear: resume, no vector
// - Global enable set: next, then vector
// - Clear watchdog on every non-reset wake-up
module swc_sleep_wake (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    // Avalon-MM slave
    input  wire logic [4:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    // Core
    input  wire logic        SLEEP_EXEC_IN,
    input  wire logic        GLOBAL_INT_ENABLE_IN,
    output logic             CORE_CLK_EN_OUT,
    output logic             PREFETCH_NEXT_OUT,
    output logic             RESUME_OUT,
    output logic             VECTOR_AFTER_NEXT_OUT,
    output logic             POWER_DOWN_FLAG_OUT,
    output logic             TIMEOUT_FLAG_OUT,
    // Watchdog
    input  wire logic        WDOG_TIMEOUT_IN,
    output logic             WDOG_CLEAR_OUT,
    output logic             WDOG_RUN_OUT,
    // Reset sources, interrupts (pins, async)
    input  wire logic        MASTER_CLEAR_PIN_IN,
    input  wire logic        BROWNOUT_RESET_IN,
    input  wire logic        POR_IN,
    input  wire logic        EXT_INT_IN,
    input  wire logic        EXT_INT_EN_IN,
    input  wire logic        PERI_INT_IN,
    input  wire logic        PERI_INT_EN_IN,
    output logic             DEVICE_RESET_OUT,
    // Keep-alive domains
    input  wire logic        TIMER1_SLEEP_CLK_IN,
    input  wire logic        ADC_RC_CLK_IN,
    output logic             LOW_FREQ_OSC_EN_OUT,
    output logic             TIMER1_RUN_OUT,
    output logic             ADC_RUN_OUT,
    output logic             IO_HOLD_OUT,
    // Interrupt
    output logic             IRQ_OUT
);
    typedef struct packed {
        swc_pkg::swc_state_t          state;
        logic [3:0]                   ctrl;
        logic [swc_pkg::EV_NUM-1:0]   irq_st;
        logic [swc_pkg::EV_NUM-1:0]   irq_en;
        logic                         pd;
        logic                         to;
        logic                         wclr;
        logic                         resume;
        logic                         vect;
        logic                         drst;
        logic                         rd_pend;
        logic [31:0]                  rdata;
    } swc_st_t;

    swc_st_t st_q;
    swc_st_t st_d;

    logic [swc_pkg::WK_NUM-1:0] pin_raw;
    logic [swc_pkg::WK_NUM-1:0] pin_s;
    logic [1:0]                 clk_src_s;
    logic [swc_pkg::WK_NUM-1:0] wake_src;
    logic                       wake_any;
    logic                       wake_rst;
    logic                       asleep;
    logic [swc_pkg::EV_NUM-1:0] ev;

    assign pin_raw = {PERI_INT_IN & PERI_INT_EN_IN,
                      EXT_INT_IN & EXT_INT_EN_IN,
                      WDOG_TIMEOUT_IN, POR_IN,
                      BROWNOUT_RESET_IN, MASTER_CLEAR_PIN_IN};

    swc_sync #(.WIDTH(swc_pkg::WK_NUM)) u_sync_wk (
        .clk_in   (CLK_IN),
        .srst_in  (SRST_IN),
        .async_in (pin_raw),
        .sync_out (pin_s)
    );

    swc_sync #(.WIDTH(2)) u_sync_ck (
        .clk_in   (CLK_IN),
        .srst_in  (SRST_IN),
        .async_in ({ADC_RC_CLK_IN, TIMER1_SLEEP_CLK_IN}),
        .sync_out (clk_src_s)
    );

    // Enables gate each source except POR; interrupts need only their own enable
    always_comb begin
        wake_src = '0;
        wake_src[swc_pkg::WK_MASTER_CLEAR_PIN]  = pin_s[swc_pkg::WK_MASTER_CLEAR_PIN]
                                    & st_q.ctrl[swc_pkg::CT_MASTER_CLEAR_PIN_EN];
        wake_src[swc_pkg::WK_BROWN] = pin_s[swc_pkg::WK_BROWN]
                                    & st_q.ctrl[swc_pkg::CT_BROWN_EN];
        wake_src[swc_pkg::WK_POR]   = pin_s[swc_pkg::WK_POR];
        wake_src[swc_pkg::WK_WDOG]  = pin_s[swc_pkg::WK_WDOG]
                                    & st_q.ctrl[swc_pkg::CT_WDOG_EN];
        wake_src[swc_pkg::WK_EXT]   = pin_s[swc_pkg::WK_EXT];
        wake_src[swc_pkg::WK_PERI]  = pin_s[swc_pkg::WK_PERI];
    end

    assign wake_any = |wake_src;
    assign wake_rst = wake_src[swc_pkg::WK_MASTER_CLEAR_PIN]
                    | wake_src[swc_pkg::WK_BROWN]
                    | wake_src[swc_pkg::WK_POR];
    assign asleep   = (st_q.state == swc_pkg::ST_SLEEP);

    always_comb begin
        st_d         = st_q;
        st_d.wclr    = 1'b0;
        st_d.resume  = 1'b0;
        st_d.vect    = 1'b0;
        ev           = '0;
        // Reset sources assert device reset whether awake or asleep; EV_RESET is set only asleep
        st_d.drst    = wake_rst;
        case (st_q.state)
            swc_pkg::ST_RUN: begin
                if (SLEEP_EXEC_IN && !wake_rst) begin
                    st_d.state = swc_pkg::ST_ENTER;
                end
            end
            swc_pkg::ST_ENTER: begin
                st_d.wclr  = 1'b1;
                st_d.pd    = 1'b0;
                st_d.to    = 1'b1;
                st_d.state = swc_pkg::ST_SLEEP;
                ev[swc_pkg::EV_SLEEP] = 1'b1;
            end
            swc_pkg::ST_SLEEP: begin
                if (wake_rst) begin
                    st_d.state = swc_pkg::ST_RUN;
                    ev[swc_pkg::EV_RESET] = 1'b1;
                end else if (wake_any) begin
                    st_d.state = swc_pkg::ST_WAKE;
                end
            end
            swc_pkg::ST_WAKE: begin
                // Clock is back this cycle; the core resumes next
                st_d.wclr   = 1'b1;
                st_d.resume = 1'b1;
                st_d.vect   = GLOBAL_INT_ENABLE_IN;
                st_d.state  = swc_pkg::ST_RUN;
                ev[swc_pkg::EV_WAKE] = 1'b1;
            end
            default: begin
                st_d.state = swc_pkg::ST_RUN;
            end
        endcase
        if (wake_rst && st_q.state != swc_pkg::ST_SLEEP) begin
            st_d.state = swc_pkg::ST_RUN;
        end

        // Bus slave: one wait cycle on reads, writes take at once
        st_d.rd_pend = AVS_READ_IN && !st_q.rd_pend;
        if (AVS_READ_IN && !st_q.rd_pend) begin
            case (AVS_ADDRESS_IN)
                {1'b0, swc_pkg::REG_CTRL}:
                    st_d.rdata = {28'h0000000, st_q.ctrl};
                {1'b0, swc_pkg::REG_STATUS}:
                    st_d.rdata = {28'h0000000, st_q.to, st_q.pd,
                                  st_q.state};
                {1'b0, swc_pkg::REG_IRQ_ST}:
                    st_d.rdata = {29'h00000000, st_q.irq_st};
                swc_pkg::REG_IRQ_EN:
                    st_d.rdata = {29'h00000000, st_q.irq_en};
                default:
                    st_d.rdata = swc_pkg::RD_ZERO;
            endcase
        end
        if (AVS_WRITE_IN) begin
            if (AVS_ADDRESS_IN == {1'b0, swc_pkg::REG_CTRL}) begin
                st_d.ctrl = AVS_WRITEDATA_IN[3:0];
            end
            if (AVS_ADDRESS_IN == swc_pkg::REG_IRQ_EN) begin
                st_d.irq_en = AVS_WRITEDATA_IN[swc_pkg::EV_NUM-1:0];
            end
            if (AVS_ADDRESS_IN == {1'b0, swc_pkg::REG_IRQ_CL}) begin
                st_d.irq_st = st_q.irq_st
                            & ~AVS_WRITEDATA_IN[swc_pkg::EV_NUM-1:0];
            end
        end
        // Set wins over a simultaneous clear
        st_d.irq_st = st_d.irq_st | ev;
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            st_q.state   <= swc_pkg::ST_RUN;
            st_q.ctrl    <= 4'h0;
            st_q.irq_st  <= '0;
            st_q.irq_en  <= '0;
            st_q.pd      <= 1'b1;
            st_q.to      <= 1'b1;
            st_q.wclr    <= 1'b0;
            st_q.resume  <= 1'b0;
            st_q.vect    <= 1'b0;
            st_q.drst    <= 1'b0;
            st_q.rd_pend <= 1'b0;
            st_q.rdata   <= swc_pkg::RD_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    assign AVS_READDATA_OUT      = st_q.rdata;
    assign AVS_WAITREQUEST_OUT   = AVS_READ_IN && !st_q.rd_pend;
    assign CORE_CLK_EN_OUT       = !asleep;
    // Next opcode stays latched in the core while its clock is off
    assign PREFETCH_NEXT_OUT     = (st_q.state == swc_pkg::ST_ENTER);
    assign RESUME_OUT            = st_q.resume;
    assign VECTOR_AFTER_NEXT_OUT = st_q.vect;
    assign POWER_DOWN_FLAG_OUT   = st_q.pd;
    assign TIMEOUT_FLAG_OUT      = st_q.to;
    assign WDOG_CLEAR_OUT        = st_q.wclr;
    assign WDOG_RUN_OUT          = st_q.ctrl[swc_pkg::CT_WDOG_EN]
                                 & (!asleep
                                 | st_q.ctrl[swc_pkg::CT_WDOG_SLP]);
    assign DEVICE_RESET_OUT      = st_q.drst;
    assign LOW_FREQ_OSC_EN_OUT   = 1'b1;
    assign TIMER1_RUN_OUT        = !asleep | clk_src_s[0];
    assign ADC_RUN_OUT           = !asleep | clk_src_s[1];
    assign IO_HOLD_OUT           = asleep;
    assign IRQ_OUT               = |(st_q.irq_st & st_q.irq_en);

    a_sleep_clk_off: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        $rose(asleep) |-> !CORE_CLK_EN_OUT && WDOG_CLEAR_OUT)
        else $error("Sleep entry without clock gate or watchdog clear");
    a_entry_flags: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        st_q.state == swc_pkg::ST_ENTER |=> !st_q.pd && st_q.to)
        else $error("Entry flags wrong");
    a_wake_wdclr: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        st_q.state == swc_pkg::ST_WAKE |=> WDOG_CLEAR_OUT && RESUME_OUT)
        else $error("Wake did not clear watchdog");
    a_wake_vector: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        RESUME_OUT |-> VECTOR_AFTER_NEXT_OUT == $past(GLOBAL_INT_ENABLE_IN))
        else $error("Vector does not follow global enable");
    a_reset_wake: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        asleep && wake_rst |=> DEVICE_RESET_OUT && !RESUME_OUT ##1 !asleep)
        else $error("Reset wake did not reset");
    a_stay_asleep: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        asleep && !wake_any |=> asleep)
        else $error("Left sleep without wake event");
    a_int_wake: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        asleep && wake_src[swc_pkg::WK_EXT] && !wake_rst
        |=> CORE_CLK_EN_OUT ##1 RESUME_OUT)
        else $error("Interrupt wake missing");
    a_io_hold: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        IO_HOLD_OUT == !CORE_CLK_EN_OUT)
        else $error("I/O hold not tied to sleep");
endmodule
`default_nettype wire

/* rtl/swc_pkg.sv */
package swc_pkg;
    // Wake source bit positions
    localparam int WK_MASTER_CLEAR_PIN  = 0;
    localparam int WK_BROWN = 1;
    localparam int WK_POR   = 2;
    localparam int WK_WDOG  = 3;
    localparam int WK_EXT   = 4;
    localparam int WK_PERI  = 5;
    localparam int WK_NUM   = 6;

    // Interrupt status bit positions
    localparam int EV_SLEEP = 0;
    localparam int EV_WAKE  = 1;
    localparam int EV_RESET = 2;
    localparam int EV_NUM   = 3;

    // Register byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_ST = 4'h8;
    localparam logic [3:0] REG_IRQ_CL = 4'hC;
    localparam logic [4:0] REG_IRQ_EN = 5'h10;

    // Control bit positions
    localparam int CT_MASTER_CLEAR_PIN_EN  = 0;
    localparam int CT_BROWN_EN = 1;
    localparam int CT_WDOG_EN  = 2;
    localparam int CT_WDOG_SLP = 3;

    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_ENTER = 2'b01,
        ST_SLEEP = 2'b10,
        ST_WAKE  = 2'b11
    } swc_state_t;
endpackage

/* rtl/swc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module swc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } swc_sync_st_t;

    swc_sync_st_t st_q;
    swc_sync_st_t st_d;

    // First stage feeds only the second
    always_comb begin
        st_d    = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;
endmodule
`default_nettype wire

/* verification/swc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
    // Clock
    input  wire logic clk_in,
    // From block
    input  wire logic core_clk_en_in,
    input  wire logic resume_in,
    input  wire logic vector_in,
    // To block
    output logic      sleep_exec_out,
    output logic      gie_out
);
    int n_resume = 0;
    int n_isr    = 0;

    initial begin
        sleep_exec_out = 1'b0;
        gie_out = 1'b0;
    end

    // A stopped core issues nothing
    task automatic do_sleep(input logic global_int_enable);
        @(posedge clk_in);
        if (core_clk_en_in) begin
            sleep_exec_out <= 1'b1;
            gie_out <= global_int_enable;
        end
        @(posedge clk_in);
        sleep_exec_out <= 1'b0;
    endtask

    // Slot after sleep holds a no-op, so resuming runs it safely
    always @(posedge clk_in) begin
        if (resume_in) begin
            n_resume <= n_resume + 1;
            if (vector_in) begin
                n_isr <= n_isr + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/swc_sleep_wake_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module swc_sleep_wake_tb_top;
    logic        clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic        wreq, slp, global_int_enable, clk_en, pref, resume, vec, pd, to;
    logic        wclr, wrun, dev_rst, lfo, t1_run, adc_run, hold, irq;
    logic        wdt = 1'b0, master_clear_pin = 1'b0, bor = 1'b0, por = 1'b0;
    logic        ext = 1'b0, ext_en = 1'b0, peri = 1'b0, peri_en = 1'b0;
    logic        t1_sel = 1'b0, adc_sel = 1'b0;
    int          fails = 0, n_checks = 0;

    always #5 clk = ~clk;

    swc_sleep_wake u_swc_sleep_wake (
        .CLK_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
        .SLEEP_EXEC_IN(slp), .GLOBAL_INT_ENABLE_IN(global_int_enable),
        .CORE_CLK_EN_OUT(clk_en), .PREFETCH_NEXT_OUT(pref),
        .RESUME_OUT(resume), .VECTOR_AFTER_NEXT_OUT(vec),
        .POWER_DOWN_FLAG_OUT(pd), .TIMEOUT_FLAG_OUT(to),
        .WDOG_TIMEOUT_IN(wdt), .WDOG_CLEAR_OUT(wclr), .WDOG_RUN_OUT(wrun),
        .MASTER_CLEAR_PIN_IN(master_clear_pin), .BROWNOUT_RESET_IN(bor), .POR_IN(por),
        .EXT_INT_IN(ext), .EXT_INT_EN_IN(ext_en), .PERI_INT_IN(peri),
        .PERI_INT_EN_IN(peri_en), .DEVICE_RESET_OUT(dev_rst),
        .TIMER1_SLEEP_CLK_IN(t1_sel), .ADC_RC_CLK_IN(adc_sel),
        .LOW_FREQ_OSC_EN_OUT(lfo), .TIMER1_RUN_OUT(t1_run),
        .ADC_RUN_OUT(adc_run), .IO_HOLD_OUT(hold), .IRQ_OUT(irq));

    swc_core_model u_swc_core_model (
        .clk_in(clk), .core_clk_en_in(clk_en), .resume_in(resume),
        .vector_in(vec), .sleep_exec_out(slp), .gie_out(global_int_enable));

    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
        end
    endtask

    // Waitrequest is looked at just before the edge that samples it
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int i;
        logic done;
        done = 1'b0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        for (i = 0; i < 20 && !done; i++) begin
            @(negedge clk);
            done = (wreq === 1'b0);
            q = rdata;
            @(posedge clk);
        end
        wr <= 1'b0;
        rd <= 1'b0;
        if (!done) begin
            fails++;
            end_of_test();
        end
    endtask

    // 0: prefetch, 1: core clock stopped, 2: resume or device reset
    task automatic wait_for(input int sel);
        int i;
        logic hit;
        hit = 1'b0;
        for (i = 0; i < 30 && !hit; i++) begin
            @(negedge clk);
            case (sel)
                0: hit = (pref === 1'b1);
                1: hit = (clk_en === 1'b0);
                default: hit = (resume === 1'b1) || (dev_rst === 1'b1);
            endcase
        end
        if (!hit) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic enter(input logic g);
        u_swc_core_model.do_sleep(g);
        wait_for(0);
        wait_for(1);
        chk("wdog_clear", 1'h1, wclr);
        chk("pd", 1'h0, pd);
        chk("to", 1'h1, to);
        chk("io_hold", 1'h1, hold);
        chk("lfosc", 1'h1, lfo);
    endtask

    task automatic s_regs();
        bus(1'b0, 5'h04, 32'h0);
        chk("status", 32'h0000000C, q);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, 5'h10, 32'h7);
        bus(1'b0, 5'h10, 32'h0);
        chk("irq_en", 32'h7, q);
    endtask

    task automatic s_int_wake();
        ext <= 1'b1;
        enter(1'b1);
        chk("irq", 1'h1, irq);
        bus(1'b0, 5'h04, 32'h0);
        chk("status", 32'h0000000A, q);
        repeat (12) @(posedge clk);
        chk("masked", 1'h0, clk_en);
        ext_en <= 1'b1;
        wait_for(2);
        chk("resume", 1'h1, resume);
        chk("vector", 1'h1, vec);
        chk("wclr", 1'h1, wclr);
        chk("clk_en", 1'h1, clk_en);
        @(posedge clk);
        ext <= 1'b0;
        ext_en <= 1'b0;
        @(negedge clk);
        chk("isr", 32'h1, u_swc_core_model.n_isr);
        bus(1'b1, 5'h0C, 32'h7);
        @(negedge clk);
        chk("irq_clr", 1'h0, irq);
    endtask

    task automatic s_wdog();
        bus(1'b1, 5'h00, 32'hC);
        t1_sel <= 1'b1;
        repeat (4) @(posedge clk);
        enter(1'b0);
        chk("wdog_run", 1'h1, wrun);
        chk("t1_run", 1'h1, t1_run);
        chk("adc_run", 1'h0, adc_run);
        wdt <= 1'b1;
        wait_for(2);
        chk("resume", 1'h1, resume);
        chk("vector", 1'h0, vec);
        chk("wclr", 1'h1, wclr);
        @(posedge clk);
        wdt <= 1'b0;
        adc_sel <= 1'b1;
        peri_en <= 1'b1;
        repeat (4) @(posedge clk);
        enter(1'b0);
        chk("adc_run", 1'h1, adc_run);
        peri <= 1'b1;
        wait_for(2);
        chk("peri", 1'h1, resume);
        @(posedge clk);
        peri <= 1'b0;
    endtask

    task automatic s_por();
        repeat (4) @(posedge clk);
        bus(1'b1, 5'h0C, 32'h7);
        enter(1'b1);
        por <= 1'b1;
        wait_for(2);
        chk("dev_rst", 1'h1, dev_rst);
        chk("resume", 1'h0, resume);
        @(posedge clk);
        por <= 1'b0;
        bus(1'b0, 5'h08, 32'h0);
        chk("rst_ev", 32'h4, q & 32'h4);
        bus(1'b1, 5'h10, 32'h0);
        @(negedge clk);
        chk("irq_off", 1'h0, irq);
        bus(1'b1, 5'h10, 32'h4);
        @(negedge clk);
        chk("irq_on", 1'h1, irq);
        chk("resumes", 32'h3, u_swc_core_model.n_resume);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        s_regs();
        s_int_wake();
        s_wdog();
        s_por();
        end_of_test();
    end
endmodule
`default_nettype wire
